// file: rtl/trim_ts_pkg.sv
/*
 * Shared constants and carrier types for the bank trim and timestamp block.
 * Assumes one 40 MHz clock and a synchronous active-high reset everywhere.
 */
package trim_ts_pkg;
    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam logic [9:0] IDX_B2_P0 = 10'h122;
    localparam logic [9:0] IDX_B2_M90 = 10'h123;
    localparam logic [9:0] IDX_B3_P0 = 10'h132;
    localparam logic [9:0] IDX_B3_M90 = 10'h133;
    localparam logic [9:0] IDX_B4_P0 = 10'h142;
    localparam logic [9:0] IDX_B4_M90 = 10'h143;
    localparam logic [9:0] IDX_B5_P0 = 10'h152;
    localparam logic [9:0] IDX_B5_M90 = 10'h153;
    localparam logic [9:0] IDX_LSB_CTRL = 10'h160;
    localparam logic [9:0] IDX_PATH_CFG = 10'h170;
    localparam int unsigned TRIM_COUNT = 8;
    localparam int unsigned BANK_COUNT = 4;
    localparam logic [9:0] TRIM_IDX [TRIM_COUNT] = '{
        IDX_B2_P0, IDX_B2_M90, IDX_B3_P0, IDX_B3_M90,
        IDX_B4_P0, IDX_B4_M90, IDX_B5_P0, IDX_B5_M90
    };

    // ==========================================================
    // Field positions
    localparam int unsigned TS_EN_BIT = 0;
    localparam int unsigned CFG_PHASE_BIT = 0;
    localparam int unsigned CFG_BYPASS_BIT = 1;
    localparam int unsigned CFG_CAL_EN_BIT = 2;
    localparam int unsigned CFG_RECV_EN_BIT = 3;
    localparam int unsigned CFG_NARROW_BIT = 4;

    // ==========================================================
    // Reset values and timing counts
    localparam logic [7:0] LSB_CTRL_RESET = 8'h00;
    localparam logic [7:0] PATH_CFG_RESET = 8'h00;
    localparam logic [1:0] ILA_CS_VALUE = 2'h0;
    localparam logic [3:0] NARROW_TOP_ZERO = 4'h0;
    localparam int unsigned SYNC_STAGES = 2;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic valid;
        logic [11:0] data;
    } sample_t;

    typedef struct packed {
        logic [7:0] phase_zero;
        logic [7:0] phase_minus90;
    } bank_trim_t;

    typedef struct packed {
        logic ts_en;
        logic cal_en;
        logic bypass;
        logic narrow;
    } lsb_mode_t;
endpackage

// file: rtl/ts_sync.sv
/*
 * Two-flop synchroniser for the timestamp pin.
 * Assumes the pin is asynchronous to i_clk and held for at least one clock.
 */
module ts_sync (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // Pin side
    input wire logic i_pin,
    // Core side
    output logic o_level
);
    // ==========================================================
    // Synchroniser
    logic meta;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            meta <= 1'b0;
            o_level <= 1'b0;
        end else begin
            meta <= i_pin;
            o_level <= meta;
        end
    end
endmodule // ts_sync

// file: rtl/lsb_merge.sv
/*
 * Output stage that overwrites the sample LSB with a control bit.
 * Assumes the timestamp bit already lines up with the sample it marks.
 */
module lsb_merge (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // Stream in
    input wire trim_ts_pkg::sample_t i_sample,
    input wire trim_ts_pkg::lsb_mode_t i_mode,
    input wire logic i_ts_bit,
    input wire logic i_cal_bit,
    // Stream out
    output trim_ts_pkg::sample_t o_sample
);
    // ==========================================================
    // Merge
    trim_ts_pkg::sample_t next_sample;

    always_comb begin
        next_sample = i_sample;
        if (i_mode.narrow) begin
            next_sample.data[11:8] = trim_ts_pkg::NARROW_TOP_ZERO;
        end
        // Timestamp only when the down-converter is bypassed
        if (i_mode.ts_en && i_mode.bypass) begin
            next_sample.data[0] = i_ts_bit;
        end else if (i_mode.cal_en) begin
            next_sample.data[0] = i_cal_bit;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_sample <= '0;
        end else begin
            o_sample <= next_sample;
        end
    end
endmodule // lsb_merge

// file: rtl/bank_timing_trim_timestamp.sv
/*
 * Bank sampling-time trim registers and sample LSB timestamp insertion,
 * reached over APB. Assumes fuse trims are steady in the clock domain,
 * samples arrive on the same clock, and the timestamp pin is asynchronous.
 */
// Decided for this implementation: the APB interface to the registers.
// How it works
// - Per-bank 8-bit trim for zero-degree phase
// - Second per-bank trim for minus-ninety phase
// - Trims load factory value, software may overwrite
// - Timestamp enable at bit 0, resets zero
// - Enabled timestamp rides in every sample LSB; here the LSB reads 0 instead while receiver enable (path_cfg bit 3) is clear
// - Timestamp only with down-converter bypassed
// - Timestamp beats calibration bit on LSB
// - Timestamp latency equals sample latency
// - Eight-bit samples keep seven data bits
// - Twelve-bit samples keep eleven data bits
// - Control bits field in lane alignment stays zero
module bank_timing_trim_timestamp (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Factory trim
    input wire trim_ts_pkg::bank_trim_t [3:0] i_fuse_trim,
    // Sample stream
    input wire trim_ts_pkg::sample_t i_sample,
    input wire logic i_cal_state,
    input wire logic i_timestamp_pin,
    output trim_ts_pkg::sample_t o_sample,
    // Bank timing and link parameters
    output logic [3:0][7:0] o_bank_trim,
    output logic [1:0] o_ila_control_bits
);
    // ==========================================================
    // Register storage
    logic [7:0] trim [trim_ts_pkg::TRIM_COUNT];
    logic [7:0] lsb_ctrl;
    logic [7:0] path_cfg;

    // ==========================================================
    // Address decode
    logic setup;
    logic access;
    logic wr;
    logic [9:0] idx;
    logic aligned;
    logic [trim_ts_pkg::TRIM_COUNT-1:0] trim_hit;
    logic lsb_hit;
    logic cfg_hit;
    logic mapped;
    logic [31:0] next_rdata;

    assign setup = i_psel && !i_penable;
    assign access = i_psel && i_penable;
    assign wr = access && i_pwrite && i_pstrb[0] && mapped;
    assign idx = i_paddr[11:2];
    assign aligned = (i_paddr[1:0] == 2'h0);
    assign lsb_hit = aligned && (idx == trim_ts_pkg::IDX_LSB_CTRL);
    assign cfg_hit = aligned && (idx == trim_ts_pkg::IDX_PATH_CFG);
    assign mapped = (|trim_hit) || lsb_hit || cfg_hit;

    genvar k;
    generate
        for (k = 0; k < trim_ts_pkg::TRIM_COUNT; k++) begin : g_trim
            assign trim_hit[k] = aligned && (idx == trim_ts_pkg::TRIM_IDX[k]);

            // Odd entries are the minus-ninety copy of the same bank
            always_ff @(posedge i_clk) begin
                if (i_srst) begin
                    if (k % 2 == 1) begin
                        trim[k] <= i_fuse_trim[k/2].phase_minus90;
                    end else begin
                        trim[k] <= i_fuse_trim[k/2].phase_zero;
                    end
                end else if (wr && trim_hit[k]) begin
                    trim[k] <= i_pwdata[7:0];
                end
            end
        end
    endgenerate

    // ==========================================================
    // Control registers
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            lsb_ctrl <= trim_ts_pkg::LSB_CTRL_RESET;
        end else if (wr && lsb_hit) begin
            lsb_ctrl <= i_pwdata[7:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            path_cfg <= trim_ts_pkg::PATH_CFG_RESET;
        end else if (wr && cfg_hit) begin
            path_cfg <= i_pwdata[7:0];
        end
    end

    // ==========================================================
    // Read path
    // Read data is captured in the setup cycle so it comes from a flop
    always_comb begin
        next_rdata = 32'h0000_0000;
        for (int i = 0; i < trim_ts_pkg::TRIM_COUNT; i++) begin
            if (trim_hit[i]) begin
                next_rdata[7:0] = trim[i];
            end
        end
        if (lsb_hit) begin
            next_rdata[7:0] = lsb_ctrl;
        end
        if (cfg_hit) begin
            next_rdata[7:0] = path_cfg;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else if (setup) begin
            o_prdata <= next_rdata;
            o_pslverr <= !mapped;
        end
    end

    // No wait states: every access phase completes at once
    assign o_pready = 1'b1;

    // ==========================================================
    // Bank trim selection
    logic phase_minus90;

    assign phase_minus90 = path_cfg[trim_ts_pkg::CFG_PHASE_BIT];

    genvar b;
    generate
        for (b = 0; b < trim_ts_pkg::BANK_COUNT; b++) begin : g_bank
            always_ff @(posedge i_clk) begin
                if (i_srst) begin
                    o_bank_trim[b] <= 8'h00;
                end else if (phase_minus90) begin
                    o_bank_trim[b] <= trim[2*b+1];
                end else begin
                    o_bank_trim[b] <= trim[2*b];
                end
            end
        end
    endgenerate

    // ==========================================================
    // Sample path
    // The pin crosses two flops, so samples are held two flops as well
    logic ts_level;
    logic ts_bit;
    logic cal_d1;
    logic cal_d2;
    trim_ts_pkg::sample_t stage1;
    trim_ts_pkg::sample_t stage2;
    trim_ts_pkg::lsb_mode_t mode;

    ts_sync u_ts_sync (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_pin(i_timestamp_pin),
        .o_level(ts_level)
    );

    // Without the receiver enable the pin is not trusted
    assign ts_bit = ts_level && path_cfg[trim_ts_pkg::CFG_RECV_EN_BIT];

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            stage1 <= '0;
            stage2 <= '0;
            cal_d1 <= 1'b0;
            cal_d2 <= 1'b0;
        end else begin
            stage1 <= i_sample;
            stage2 <= stage1;
            cal_d1 <= i_cal_state;
            cal_d2 <= cal_d1;
        end
    end

    assign mode.ts_en = lsb_ctrl[trim_ts_pkg::TS_EN_BIT];
    assign mode.cal_en = path_cfg[trim_ts_pkg::CFG_CAL_EN_BIT];
    assign mode.bypass = path_cfg[trim_ts_pkg::CFG_BYPASS_BIT];
    assign mode.narrow = path_cfg[trim_ts_pkg::CFG_NARROW_BIT];

    lsb_merge u_lsb_merge (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_sample(stage2),
        .i_mode(mode),
        .i_ts_bit(ts_bit),
        .i_cal_bit(cal_d2),
        .o_sample(o_sample)
    );

    // The inserted bit is never advertised to the receiver
    assign o_ila_control_bits = trim_ts_pkg::ILA_CS_VALUE;

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);

    logic ts_active;

    assign ts_active = mode.ts_en && mode.bypass && path_cfg[trim_ts_pkg::CFG_RECV_EN_BIT];

    sequence s_ts_high;
        i_sample.valid && i_timestamp_pin && ts_active ##1 ts_active [*2];
    endsequence

    sequence s_ts_low;
        i_sample.valid && !i_timestamp_pin && ts_active ##1 ts_active [*2];
    endsequence

    chk_trim_reset: assert property (
        disable iff (1'b0) i_srst ##1 !i_srst |-> trim[0] == $past(i_fuse_trim[0].phase_zero, 1)
    ) else $error("bank trim did not load factory value");

    chk_trim_write: assert property (
        wr && trim_hit[2] |=> trim[2] == $past(i_pwdata[7:0]) ##1 o_bank_trim[1] ==
            (phase_minus90 ? trim[3] : trim[2])
    ) else $error("bank trim write not applied");

    chk_phase_select: assert property (
        phase_minus90 [*2] |-> o_bank_trim[3] == $past(trim[7])
    ) else $error("minus-ninety trim not selected");

    chk_lsb_reset: assert property (
        disable iff (1'b0) i_srst |=> lsb_ctrl == 8'h00 && !mode.ts_en
    ) else $error("timestamp enable not cleared by reset");

    chk_ts_high: assert property (
        s_ts_high |=> o_sample.valid && o_sample.data[0]
    ) else $error("timestamp high not in sample lsb");

    chk_ts_latency: assert property (
        s_ts_low |=> o_sample.valid && !o_sample.data[0]
    ) else $error("timestamp latency differs from sample latency");

    chk_ts_priority: assert property (
        ts_active && mode.cal_en && stage2.valid |=> o_sample.data[0] == $past(ts_level)
    ) else $error("calibration bit displaced timestamp");

    chk_decim_only: assert property (
        !mode.bypass && !mode.cal_en && !mode.narrow && stage2.valid
            |=> o_sample.data == $past(stage2.data)
    ) else $error("lsb altered while decimating");

    chk_narrow_width: assert property (
        mode.narrow && ts_active && stage2.valid |=> o_sample.data[11:8] == 4'h0 &&
            o_sample.data[7:1] == $past(stage2.data[7:1])
    ) else $error("eight-bit sample data bits wrong");

    chk_wide_width: assert property (
        !mode.narrow && ts_active && stage2.valid |=>
            o_sample.data[11:1] == $past(stage2.data[11:1])
    ) else $error("twelve-bit sample data bits wrong");

    chk_ila_zero: assert property (
        $rose(mode.ts_en) |-> o_ila_control_bits == 2'h0 [*3]
    ) else $error("control bits advertised in lane alignment");

    chk_recv_gate: assert property (
        !path_cfg[trim_ts_pkg::CFG_RECV_EN_BIT] && mode.ts_en && mode.bypass && stage2.valid
            |=> !o_sample.data[0]
    ) else $error("timestamp passed without receiver enable");

    chk_apb_error: assert property (
        setup && !mapped |=> o_pslverr && o_pready && $stable(lsb_ctrl)
    ) else $error("unmapped access not flagged");

    // ==========================================================
    // Register and stream step checks
    // Read data trails the setup cycle by one edge, hence the $past on the source
    chk_lsb_read: assert property (
        setup && lsb_hit |=> o_prdata == {24'h000000, $past(lsb_ctrl)}
    ) else $error("sample lsb control read wrong");

    chk_lsb_write: assert property (
        wr && lsb_hit |=> lsb_ctrl == $past(i_pwdata[7:0]) && mode.ts_en == $past(i_pwdata[0])
    ) else $error("sample lsb control write not applied");

    // One trim entry stands for all; the decode is a single generate loop
    chk_trim_read: assert property (
        setup && trim_hit[5] |=> o_prdata == {24'h000000, $past(trim[5])}
    ) else $error("bank trim read wrong");

    chk_m90_write: assert property (
        wr && trim_hit[7] |=> trim[7] == $past(i_pwdata[7:0])
    ) else $error("minus-ninety trim write not applied");

    chk_strobe_gate: assert property (
        access && i_pwrite && !i_pstrb[0] |=> $stable(trim[0]) && $stable(lsb_ctrl)
    ) else $error("write without low byte strobe changed a register");

    // Errors must not leak into storage; the decode gates the write
    chk_unmapped_write: assert property (
        access && i_pwrite && !mapped |=> $stable(lsb_ctrl) && $stable(path_cfg)
    ) else $error("unmapped write changed a control register");

    chk_pslverr_clear: assert property (
        setup && mapped |=> !o_pslverr
    ) else $error("mapped access flagged as error");

    chk_phase_zero: assert property (
        !phase_minus90 [*2] |-> o_bank_trim[0] == $past(trim[0])
    ) else $error("zero-degree trim not selected");

    chk_bank_m90: assert property (
        phase_minus90 [*2] |-> o_bank_trim[0] == $past(trim[1])
    ) else $error("minus-ninety trim of first bank not selected");

    // No back-pressure, so every sample leaves exactly three edges later
    chk_valid_latency: assert property (
        i_sample.valid |-> ##3 o_sample.valid
    ) else $error("sample valid latency wrong");

    chk_cal_insert: assert property (
        !(mode.ts_en && mode.bypass) && mode.cal_en && stage2.valid |=>
            o_sample.data[0] == $past(cal_d2)
    ) else $error("calibration bit not in sample lsb");

    chk_ts_decimating: assert property (
        mode.ts_en && !mode.bypass && !mode.cal_en && stage2.valid |=>
            o_sample.data[0] == $past(stage2.data[0])
    ) else $error("timestamp inserted while decimating");
endmodule // bank_timing_trim_timestamp

// file: verif/jesd_rx_model.sv
/*
 * Behavioural sink standing in for the lane receiver at the sample output.
 * Assumes samples and the lane alignment control-bit field share i_clk.
 */
module jesd_rx_model (
    // Clock
    input wire logic i_clk,
    // Lane side
    input wire trim_ts_pkg::sample_t i_sample,
    input wire logic [1:0] i_cs_field,
    // Observed by the bench
    output trim_ts_pkg::sample_t o_word,
    output logic o_cs_ok
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Capture
    // No back-pressure exists, so every word is taken on every edge
    always_ff @(posedge i_clk) begin
        o_word <= i_sample;
        o_cs_ok <= (i_cs_field === 2'h0);
    end
endmodule // jesd_rx_model

// file: verif/tb_top.sv
/*
 * Self-checking bench: APB register tests and sample stream LSB tests.
 * Assumes the zero-wait APB slave and 3-edge sample path of the design.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Signals
    logic i_clk, i_srst, i_psel, i_penable, i_pwrite, i_cal_state, i_timestamp_pin;
    logic [11:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, rd;
    logic [3:0] i_pstrb;
    logic o_pready, o_pslverr, err, cs_ok;
    trim_ts_pkg::bank_trim_t [3:0] i_fuse_trim;
    trim_ts_pkg::sample_t i_sample, o_sample, rx_word;
    logic [3:0][7:0] o_bank_trim;
    logic [1:0] o_ila_control_bits;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [7:0] cfgs [6] = '{8'h0E, 8'h1E, 8'h0C, 8'h0A, 8'h06, 8'h08};
    logic [7:0] lsbs [6] = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h01, 8'h01};
    logic [12:0] exp_word;

    bank_timing_trim_timestamp dut (.i_clk(i_clk), .i_srst(i_srst), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .i_pstrb(i_pstrb), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_fuse_trim(i_fuse_trim), .i_sample(i_sample), .i_cal_state(i_cal_state),
        .i_timestamp_pin(i_timestamp_pin), .o_sample(o_sample), .o_bank_trim(o_bank_trim),
        .o_ila_control_bits(o_ila_control_bits));
    jesd_rx_model rx (.i_clk(i_clk), .i_sample(o_sample), .i_cs_field(o_ila_control_bits),
        .o_word(rx_word), .o_cs_ok(cs_ok));

    // ==========================================================
    // Helpers
    function automatic logic [7:0] fuse(int i);
        return (i % 2 == 0) ? 8'(8'h30 + i) : 8'(8'hC0 + i);
    endfunction
    function automatic logic [11:0] dat(int k);
        return 12'h9C3 ^ 12'(k * 37);
    endfunction
    function automatic logic [11:0] expect_data(int k, logic [7:0] cfg, logic [7:0] lsb);
        logic [11:0] d;
        logic b;
        d = cfg[4] ? (dat(k) & 12'h0FF) : dat(k);
        b = (lsb[0] & cfg[1]) ? ((k % 3 == 0) & cfg[3]) : (cfg[2] ? k[1] : d[0]);
        return {d[11:1], b};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Holds the request until pready is sampled high at a rising edge
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd,
                       input logic [3:0] strb);
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= wr;
        i_paddr <= {idx, 2'b00};
        i_pwdata <= {24'h0, wd};
        i_pstrb <= strb;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do @(posedge i_clk); while (o_pready !== 1'b1);
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task automatic conclude;
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ==========================================================
    // Clock and timeout
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 4000) begin
            failures++;
            conclude();
        end
    end

    // ==========================================================
    // Tests
    initial begin
        {i_psel, i_penable, i_pwrite, i_cal_state, i_timestamp_pin} = 5'h00;
        i_paddr = 12'h000;
        i_pwdata = 32'h0;
        i_pstrb = 4'hF;
        i_sample = '0;
        for (int b = 0; b < 4; b++) i_fuse_trim[b] = {fuse(2 * b), fuse(2 * b + 1)};
        i_srst = 1'b1;
        repeat (8) @(posedge i_clk);
        i_srst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, trim_ts_pkg::TRIM_IDX[i], 8'h00, 4'hF);
            check(rd, {24'h0, fuse(i)});
        end
        for (int b = 0; b < 4; b++) check(o_bank_trim[b], fuse(2 * b));
        apb(1'b0, trim_ts_pkg::IDX_LSB_CTRL, 8'h00, 4'hF);
        check(rd, 32'h0);
        check(o_ila_control_bits, 2'h0);
        $display("Reset values test done");
        for (int i = 0; i < 8; i++) apb(1'b1, trim_ts_pkg::TRIM_IDX[i], 8'(8'h0F + 17 * i), 4'hF);
        apb(1'b1, trim_ts_pkg::TRIM_IDX[0], 8'hEE, 4'h0);
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, trim_ts_pkg::TRIM_IDX[i], 8'h00, 4'hF);
            check(rd, {24'h0, 8'(8'h0F + 17 * i)});
        end
        apb(1'b1, trim_ts_pkg::IDX_PATH_CFG, 8'h01, 4'hF);
        apb(1'b0, trim_ts_pkg::IDX_PATH_CFG, 8'h00, 4'hF);
        check(rd, 32'h1);
        for (int b = 0; b < 4; b++) check(o_bank_trim[b], 8'(8'h0F + 17 * (2 * b + 1)));
        apb(1'b1, trim_ts_pkg::IDX_LSB_CTRL, 8'hFF, 4'hF);
        apb(1'b0, trim_ts_pkg::IDX_LSB_CTRL, 8'h00, 4'hF);
        check(rd, 32'h0000_00FF);
        apb(1'b0, 10'h161, 8'h00, 4'hF);
        check({rd[30:0], err}, 32'h1);
        apb(1'b1, 10'h161, 8'h5A, 4'hF);
        check(err, 1'b1);
        apb(1'b0, trim_ts_pkg::IDX_LSB_CTRL, 8'h00, 4'hF);
        check(rd, 32'h0000_00FF);
        $display("Register write test done");
        // Each row is one output mode; the expected LSB follows the priority order
        for (int m = 0; m < 6; m++) begin
            apb(1'b1, trim_ts_pkg::IDX_PATH_CFG, cfgs[m], 4'hF);
            apb(1'b1, trim_ts_pkg::IDX_LSB_CTRL, lsbs[m], 4'hF);
            for (int j = 0; j < 16; j++) begin
                @(posedge i_clk);
                i_sample <= {1'b1, dat(j)};
                i_timestamp_pin <= (j % 3 == 0);
                i_cal_state <= j[1];
                #1;
                if (j >= 4) begin
                    exp_word = {1'b1, expect_data(j - 4, cfgs[m], lsbs[m])};
                    check(rx_word, exp_word);
                end
            end
            check(cs_ok, 1'b1);
            $display("Stream mode %0d test done", m);
        end
        // Reset in mid-run must bring back the factory trims over the written ones
        @(posedge i_clk);
        i_srst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_srst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, trim_ts_pkg::TRIM_IDX[i], 8'h00, 4'hF);
            check(rd, {24'h0, fuse(i)});
        end
        apb(1'b0, trim_ts_pkg::IDX_LSB_CTRL, 8'h00, 4'hF);
        check(rd, 32'h0);
        for (int b = 0; b < 4; b++) check(o_bank_trim[b], fuse(2 * b));
        $display("Mid-run reset test done");
        conclude();
    end
endmodule // tb_top
